// [src/rcs_reset_cause.sv]
// Added by the designer: the address map and the strobed register port.
`timescale 1ns/1ps
module rcs_reset_cause (
   input  wire logic        mclk,
   input  wire logic        nrst,
   input  wire logic [3:0]  addr,
   input  wire logic [15:0] wrData,
   input  wire logic        wrStb,
   input  wire logic        rdStb,
   output logic      [15:0] rdData,
   input  wire logic        deepHaltEvt,
   input  wire logic        lightHaltEvt,
   input  wire logic        supplyDipEvt,
   input  wire logic        powerUpEvt,
   input  wire logic [1:0]  watchdogConfigEnableField,
   output logic             watchdogEnable,
   output logic             irq
);
   rcs_reg_if regs ();

   logic [3:0]  events;
   logic        softEn_q;
   logic        softEn_d;
   logic        wdEn_q;
   logic        wdEn_d;
   logic [3:0]  istat_q;
   logic [3:0]  istat_d;
   logic [3:0]  imask_q;
   logic [3:0]  imask_d;
   logic        irq_q;
   logic        irq_d;
   logic [15:0] rdData_q;
   logic [15:0] rdData_d;

   function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   always_comb begin
      events = 4'h0;
      events[rcs_pkg::DEEPHALT_BIT]  = deepHaltEvt;
      events[rcs_pkg::LIGHTHALT_BIT] = lightHaltEvt;
      events[rcs_pkg::SUPPLYDIP_BIT] = supplyDipEvt;
      events[rcs_pkg::POWERUP_BIT]   = powerUpEvt;
   end

   assign regs.events = events;
   assign regs.wrEn   = wrStb && hit(addr, rcs_pkg::RCS_CAUSE_OFS);
   assign regs.wrVal  = wrData[3:0];
   assign regs.wrMask = 4'hF;

   rcs_flag_store flagStore (
      .mclk (mclk),
      .nrst (nrst),
      .regs (regs)
   );

   always_comb begin
      softEn_d = softEn_q;
      if (wrStb && hit(addr, rcs_pkg::RCS_WDCTL_OFS)) begin
         softEn_d = wrData[rcs_pkg::WD_SOFT_BIT];
      end
      // unprogrammed config overrides the soft enable
      wdEn_d = (watchdogConfigEnableField == rcs_pkg::WD_CFG_UNPROG) | softEn_d;
   end

   always_comb begin
      istat_d = istat_q;
      if (rdStb && hit(addr, rcs_pkg::RCS_IRQSTAT_OFS)) begin
         istat_d = 4'h0;
      end
      istat_d = istat_d | events;
      imask_d = imask_q;
      if (wrStb && hit(addr, rcs_pkg::RCS_IRQMASK_OFS)) begin
         imask_d = wrData[3:0];
      end
      irq_d = |(istat_d & imask_d);
   end

   always_comb begin
      rdData_d = 16'h0000;
      if (rdStb) begin
         unique case (addr)
            rcs_pkg::RCS_CAUSE_OFS:   rdData_d = {12'h000, regs.flags};
            rcs_pkg::RCS_WDCTL_OFS:   rdData_d = {14'h0, wdEn_q, softEn_q};
            rcs_pkg::RCS_IRQSTAT_OFS: rdData_d = {12'h000, istat_q};
            rcs_pkg::RCS_IRQMASK_OFS: rdData_d = {12'h000, imask_q};
            default:                  rdData_d = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         softEn_q <= 1'b0;
         wdEn_q   <= 1'b0;
         istat_q  <= 4'h0;
         imask_q  <= rcs_pkg::MASK_RST;
         irq_q    <= 1'b0;
         rdData_q <= 16'h0000;
      end else begin
         softEn_q <= softEn_d;
         wdEn_q   <= wdEn_d;
         istat_q  <= istat_d;
         imask_q  <= imask_d;
         irq_q    <= irq_d;
         rdData_q <= rdData_d;
      end
   end

   assign rdData         = rdData_q;
   assign watchdogEnable = wdEn_q;
   assign irq            = irq_q;
endmodule : rcs_reset_cause

// [src/rcs_pkg.sv]
package rcs_pkg;
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 16;
   // register offsets
   localparam logic [3:0] RCS_CAUSE_OFS   = 4'h0;
   localparam logic [3:0] RCS_WDCTL_OFS   = 4'h1;
   localparam logic [3:0] RCS_IRQSTAT_OFS = 4'h2;
   localparam logic [3:0] RCS_IRQMASK_OFS = 4'h3;
   // reset-cause field positions
   localparam int unsigned POWERUP_BIT   = 0;
   localparam int unsigned SUPPLYDIP_BIT = 1;
   localparam int unsigned LIGHTHALT_BIT = 2;
   localparam int unsigned DEEPHALT_BIT  = 3;
   localparam int unsigned NUM_FLAGS     = 4;
   // watchdog control field positions
   localparam int unsigned WD_SOFT_BIT   = 0;
   localparam int unsigned WD_ACTIVE_BIT = 1;
   // reset values
   localparam logic [3:0] CAUSE_RST      = 4'h0;
   localparam logic [3:0] MASK_RST       = 4'h0;
   localparam logic [1:0] WD_CFG_UNPROG  = 2'h3;
endpackage : rcs_pkg

// [src/rcs_reg_if.sv]
`timescale 1ns/1ps
interface rcs_reg_if;
   logic [3:0] wrMask;
   logic [3:0] wrVal;
   logic       wrEn;
   logic [3:0] events;
   logic [3:0] flags;
   modport owner (input wrMask, input wrVal, input wrEn, input events, output flags);
   modport user  (output wrMask, output wrVal, output wrEn, output events, input flags);
endinterface : rcs_reg_if

// [src/rcs_flag_store.sv]
`timescale 1ns/1ps
module rcs_flag_store (
   input  wire logic mclk,
   input  wire logic nrst,
   rcs_reg_if.owner  regs
);
   logic [3:0] flags_q;
   logic [3:0] flags_d;

   always_comb begin
      flags_d = flags_q;
      if (regs.wrEn) begin
         // only the enabled lanes take the written value
         flags_d = (flags_q & ~regs.wrMask) | (regs.wrVal & regs.wrMask);
      end
      // hardware events win over a software write in the same cycle
      flags_d = flags_d | regs.events;
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         flags_q <= rcs_pkg::CAUSE_RST;
      end else begin
         flags_q <= flags_d;
      end
   end

   assign regs.flags = flags_q;
endmodule : rcs_flag_store

// [tb/rcs_reset_cause_chk.sv]
`timescale 1ns/1ps
module rcs_reset_cause_chk (
   input wire logic        mclk,
   input wire logic        nrst,
   input wire logic [3:0]  addr,
   input wire logic [15:0] wrData,
   input wire logic        wrStb,
   input wire logic        rdStb,
   input wire logic [15:0] rdData,
   input wire logic        deepHaltEvt,
   input wire logic        lightHaltEvt,
   input wire logic        supplyDipEvt,
   input wire logic        powerUpEvt,
   input wire logic [1:0]  watchdogConfigEnableField,
   input wire logic        watchdogEnable,
   input wire logic        irq
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   wire rd0 = rdStb && addr == rcs_pkg::RCS_CAUSE_OFS;
   wire wr0 = wrStb && addr == rcs_pkg::RCS_CAUSE_OFS;
   wire evt = deepHaltEvt | lightHaltEvt | supplyDipEvt | powerUpEvt;
   wire cfg3 = watchdogConfigEnableField == 2'h3;
   a_deep_halt: assert property (deepHaltEvt ##2 rd0 |=> rdData[3])
      else $error("flag lost");
   a_light_halt: assert property (lightHaltEvt ##2 rd0 |=> rdData[2])
      else $error("flag lost");
   a_supply_dip: assert property (supplyDipEvt ##2 rd0 |=> rdData[1])
      else $error("flag lost");
   a_power_up: assert property (powerUpEvt ##2 rd0 |=> rdData[0])
      else $error("flag lost");
   a_soft_write: assert property (wr0 && !evt ##1 !evt && !wrStb ##1 rd0
      |=> rdData[3:0] == $past(wrData[3:0], 3)) else $error("write lost");
   a_no_reset: assert property (wr0 && $stable(watchdogConfigEnableField)
      |=> $stable(watchdogEnable)) else $error("write reset");
   a_wd_forced: assert property (cfg3 |=> watchdogEnable)
      else $error("watchdog off");
   a_flag_sticky: assert property (rd0 ##1 !wrStb ##1 rd0
      |=> ($past(rdData[3:0], 2) & ~rdData[3:0]) == 4'h0) else $error("flag dropped");
   c_write: cover property (wr0);
   c_irq: cover property (irq);
   c_forced: cover property (cfg3 && watchdogEnable);
endmodule : rcs_reset_cause_chk
bind rcs_reset_cause rcs_reset_cause_chk chk (.*);

// [tb/testbench.sv]
`timescale 1ns/1ps
module testbench;
   localparam logic [3:0] CAU = rcs_pkg::RCS_CAUSE_OFS, WDC = rcs_pkg::RCS_WDCTL_OFS;
   localparam logic [3:0] IST = rcs_pkg::RCS_IRQSTAT_OFS, IMK = rcs_pkg::RCS_IRQMASK_OFS;
   logic        mclk = 1'b0, nrst = 1'b0, wrStb = 1'b0, rdStb = 1'b0, watchdogEnable, irq;
   logic        deepHaltEvt = 1'b0, lightHaltEvt = 1'b0, supplyDipEvt = 1'b0, powerUpEvt = 1'b0;
   logic [3:0]  addr = 4'h0;
   logic [15:0] wrData = 16'h0000, rdData;
   logic [1:0]  watchdogConfigEnableField = 2'h0;
   int          miscompares = 0, n_compared = 0;
   always #5 mclk = ~mclk;
   rcs_reset_cause uut (.*);
   task automatic cmp(string what, logic [15:0] seen, logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : cmp
   task automatic wr(logic [3:0] a, logic [15:0] d);
      @(posedge mclk) {addr, wrData, wrStb} <= {a, d, 1'b1};
      @(posedge mclk) wrStb <= 1'b0;
   endtask : wr
   task automatic rd(logic [3:0] a, logic [15:0] e);
      @(posedge mclk) {addr, rdStb} <= {a, 1'b1};
      @(posedge mclk) rdStb <= 1'b0;
      #1 cmp("rdData", rdData, e);
   endtask : rd
   task automatic pulse(logic [3:0] e);
      @(posedge mclk) {deepHaltEvt, lightHaltEvt, supplyDipEvt, powerUpEvt} <= e;
      @(posedge mclk) {deepHaltEvt, lightHaltEvt, supplyDipEvt, powerUpEvt} <= 4'h0;
   endtask : pulse
   // outputs are registered, so let two edges land before looking
   task automatic flag(string what, ref logic v, input logic e);
      repeat (2) @(negedge mclk);
      cmp(what, {15'h0000, v}, {15'h0000, e});
   endtask : flag
   task automatic wrap_up();
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : wrap_up
   initial begin
      #20000;
      miscompares++;
      wrap_up();
   end
   initial begin
      repeat (10) @(posedge mclk);
      nrst <= 1'b1;
      flag("watchdogEnable", watchdogEnable, 1'b0);
      rd(CAU, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         pulse(4'h1 << i);
         rd(CAU, 16'h0001 << i);
         rd(CAU, 16'h0001 << i);
         wr(CAU, 16'h0000);
         rd(CAU, 16'h0000);
      end
      $display("flags done");
      @(posedge mclk) watchdogConfigEnableField <= 2'h3;
      wr(CAU, 16'h000F);
      flag("watchdogEnable", watchdogEnable, 1'b1);
      rd(CAU, 16'h000F);
      wr(WDC, 16'h0000);
      rd(WDC, 16'h0002);
      @(posedge mclk) watchdogConfigEnableField <= 2'h0;
      rd(WDC, 16'h0000);
      wr(WDC, 16'h0001);
      rd(WDC, 16'h0003);
      $display("watchdog done");
      rd(IST, 16'h000F);
      rd(IST, 16'h0000);
      wr(IMK, 16'h0002);
      pulse(4'h1);
      flag("irq", irq, 1'b0);
      pulse(4'h2);
      flag("irq", irq, 1'b1);
      rd(IST, 16'h0003);
      flag("irq", irq, 1'b0);
      wr(4'hF, 16'hFFFF);
      rd(4'hF, 16'h0000);
      rd(IMK, 16'h0002);
      $display("irq done");
      wrap_up();
   end
endmodule : testbench
